// [core/rssa_alu.sv]
// Rotate, subtract and skip datapath with its Wishbone register slave.
//
// Notes on behaviour
// - Rotate left through carry: bit7 to carry.
// - Accumulator variant: result to accumulator, memory kept.
// - Plain rotate right in memory, flags untouched.
// - Plain rotate right into accumulator, memory kept.
// - Rotate right through carry: bit0 to carry.
// - Accumulator variant: result to accumulator, memory kept.
// - Acc plus inverted byte plus carry, four flags.
// - Same borrow subtract, result back to memory.
// - Decrement memory, skip on zero, two cycles when skipping, else one.
// - Decrement into accumulator, skip on zero.
// - Byte set writes all ones, no flags.
// - Bit set touches only selected bit.
// - Increment memory, skip on zero, two cycles when skipping, else one.
// - Increment into accumulator, skip on zero.
// - Skip when selected memory bit nonzero.
// - Subtract memory byte, accumulator or memory destination.
// - Subtract immediate into accumulator, four flags.
// - Swap nibbles of memory byte, no flags.
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`include "rssa_defs.svh"

module rssa_alu
	import rssa_pkg::*;
#(
	parameter int DW = 8
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone classic slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Core side status.
	output logic skip_o,
	output rssa_flags_t flags_o
);

	// Operand and result storage.
	logic [DW-1:0] mem_r;
	logic [DW-1:0] acc_r;
	logic [DW-1:0] imm_r;
	rssa_flags_t flags_r;
	// Latched operation and bit index.
	rssa_op_t op_r;
	logic [2:0] bit_r;
	// Sequencer state.
	rssa_state_t state_r;
	// Result of the last operation: skip taken and cycles used.
	logic skipped_r;
	logic [1:0] cycles_r;
	// Bus handshake.
	logic ack_r;
	logic [31:0] rdat_r;
	logic skip_r;

	// Combinational results of the current operation.
	logic [DW-1:0] mem_nxt;
	logic [DW-1:0] acc_nxt;
	rssa_flags_t flags_nxt;
	logic skip_nxt;

	// Adder terms for the subtract family.
	logic [DW-1:0] sub_b;
	logic sub_cin;
	logic [DW:0] sum;
	logic [4:0] lo_sum;
	logic [DW-1:0] dec_v;
	logic [DW-1:0] inc_v;

	// Bus request decode.
	logic bus_req;
	logic bus_wr;
	logic ctrl_wr;
	logic idle;

	assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;
	assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
	assign idle = (state_r == st_idle);
	// A new operation starts only from idle; a busy start is dropped.
	assign ctrl_wr = bus_wr && idle && (wb_adr_i == `RSSA_OFF_CTRL);

	// Ports come straight from flip-flops.
	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;
	assign skip_o = skip_r;
	assign flags_o = flags_r;

	// Second operand and carry in: memory or immediate, with or without borrow.
	always_comb begin
		if (op_r == op_minus_imm) begin
			sub_b = ~imm_r;
		end else begin
			sub_b = ~mem_r;
		end
		if (op_r == op_minus_with_borrow || op_r == op_minus_with_borrow_to_mem) begin
			sub_cin = flags_r.c;
		end else begin
			sub_cin = 1'b1;
		end
	end

	// Subtract as an add of the inverted operand; half carry from the low nibble.
	assign sum = {1'b0, acc_r} + {1'b0, sub_b} + {{DW{1'b0}}, sub_cin};
	assign lo_sum = {1'b0, acc_r[3:0]} + {1'b0, sub_b[3:0]} + {4'h0, sub_cin};
	assign dec_v = mem_r - {{(DW-1){1'b0}}, 1'b1};
	assign inc_v = mem_r + {{(DW-1){1'b0}}, 1'b1};

	// Operation decode: each case gives the new memory, accumulator, flags and skip.
	always_comb begin
		mem_nxt = mem_r;
		acc_nxt = acc_r;
		flags_nxt = flags_r;
		skip_nxt = 1'b0;
		case (op_r)
			op_rotate_left_through_cy: begin
				mem_nxt = {mem_r[DW-2:0], flags_r.c};
				flags_nxt.c = mem_r[DW-1];
			end
			op_rotate_left_through_cy_to_accum: begin
				acc_nxt = {mem_r[DW-2:0], flags_r.c};
				flags_nxt.c = mem_r[DW-1];
			end
			op_rotate_right_plain: begin
				mem_nxt = {mem_r[0], mem_r[DW-1:1]};
			end
			op_rotate_right_to_accum: begin
				acc_nxt = {mem_r[0], mem_r[DW-1:1]};
			end
			op_rotate_right_through_cy: begin
				mem_nxt = {flags_r.c, mem_r[DW-1:1]};
				flags_nxt.c = mem_r[0];
			end
			op_rotate_right_through_cy_to_accum: begin
				acc_nxt = {flags_r.c, mem_r[DW-1:1]};
				flags_nxt.c = mem_r[0];
			end
			op_minus_with_borrow, op_minus, op_minus_imm,
			op_minus_with_borrow_to_mem, op_minus_to_mem: begin
				// Overflow when both addends agree in sign and the sum does not.
				flags_nxt.signed_range_flag = (acc_r[DW-1] == sub_b[DW-1]) && (sum[DW-1] != acc_r[DW-1]);
				flags_nxt.z = (sum[DW-1:0] == '0);
				flags_nxt.half_carry_flag = lo_sum[4];
				flags_nxt.c = sum[DW];
				if (op_r == op_minus_with_borrow_to_mem || op_r == op_minus_to_mem) begin
					mem_nxt = sum[DW-1:0];
				end else begin
					acc_nxt = sum[DW-1:0];
				end
			end
			op_decrement_skip_zero: begin
				mem_nxt = dec_v;
				skip_nxt = (dec_v == '0);
			end
			op_decrement_to_accum_skip_zero: begin
				acc_nxt = dec_v;
				skip_nxt = (dec_v == '0);
			end
			op_increment_skip_zero: begin
				mem_nxt = inc_v;
				skip_nxt = (inc_v == '0);
			end
			op_increment_to_accum_skip_zero: begin
				acc_nxt = inc_v;
				skip_nxt = (inc_v == '0);
			end
			op_skip_bit_nonzero: begin
				skip_nxt = mem_r[bit_r];
			end
			op_set_byte: begin
				mem_nxt = `RSSA_ALL_ONES;
			end
			op_set_bit: begin
				mem_nxt[bit_r] = 1'b1;
			end
			op_swap_nibbles: begin
				mem_nxt = {mem_r[3:0], mem_r[7:4]};
			end
			default: begin
				// Unknown codes run one cycle and change nothing.
				skip_nxt = 1'b0;
			end
		endcase
	end

	// Sequencer: one execute cycle, plus a dummy cycle when the next fetch is dropped.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= st_idle;
		end else begin
			case (state_r)
				st_idle: begin
					if (ctrl_wr) begin
						state_r <= st_exec;
					end
				end
				st_exec: begin
					// Zero increment or decrement result, or a set tested bit, discards the prefetch.
					if (skip_nxt) begin
						state_r <= st_dummy;
					end else begin
						state_r <= st_idle;
					end
				end
				st_dummy: begin
					state_r <= st_idle;
				end
				default: begin
					state_r <= st_idle;
				end
			endcase
		end
	end

	// Control register: latch operation code and bit index on start.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			op_r <= op_rotate_left_through_cy;
			bit_r <= 3'h0;
		end else if (ctrl_wr) begin
			op_r <= rssa_op_t'(wb_dat_i[`RSSA_CTRL_OP_MSB:`RSSA_CTRL_OP_LSB]);
			bit_r <= wb_dat_i[`RSSA_CTRL_BIT_MSB:`RSSA_CTRL_BIT_LSB];
		end
	end

	// Memory operand: software load while idle, result write in execute.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mem_r <= `RSSA_RST_BYTE;
		end else if (state_r == st_exec) begin
			mem_r <= mem_nxt;
		end else if (bus_wr && idle && wb_adr_i == `RSSA_OFF_MEM) begin
			mem_r <= wb_dat_i[DW-1:0];
		end
	end

	// Accumulator: software load while idle, result write in execute.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_r <= `RSSA_RST_BYTE;
		end else if (state_r == st_exec) begin
			acc_r <= acc_nxt;
		end else if (bus_wr && idle && wb_adr_i == `RSSA_OFF_ACC) begin
			acc_r <= wb_dat_i[DW-1:0];
		end
	end

	// Immediate operand, written by software only.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			imm_r <= `RSSA_RST_BYTE;
		end else if (bus_wr && idle && wb_adr_i == `RSSA_OFF_IMM) begin
			imm_r <= wb_dat_i[DW-1:0];
		end
	end

	// Flags: result update in execute, otherwise software may preload them.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_r <= `RSSA_RST_FLAGS;
		end else if (state_r == st_exec) begin
			flags_r <= flags_nxt;
		end else if (bus_wr && idle && wb_adr_i == `RSSA_OFF_FLAGS) begin
			flags_r <= wb_dat_i[`RSSA_FL_SIGNED_RANGE:`RSSA_FL_C];
		end
	end

	// Skip indication: high for the dummy cycle that replaces the dropped fetch.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			skip_r <= 1'b0;
		end else begin
			skip_r <= (state_r == st_exec) && skip_nxt;
		end
	end

	// Record of the last operation for the status register.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			skipped_r <= 1'b0;
			cycles_r <= 2'h0;
		end else if (state_r == st_exec) begin
			skipped_r <= skip_nxt;
			cycles_r <= skip_nxt ? `RSSA_CYC_SKIP : `RSSA_CYC_RUN;
		end
	end

	// Bus acknowledge: one cycle after the request, dropped the cycle after.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= bus_req;
		end
	end

	// Read data: registered with the acknowledge; unmapped offsets read zero.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_r <= 32'h0000_0000;
		end else if (bus_req) begin
			rdat_r <= 32'h0000_0000;
			case (wb_adr_i)
				`RSSA_OFF_CTRL: begin
					rdat_r[`RSSA_CTRL_BIT_MSB:0] <= {bit_r, op_r};
				end
				`RSSA_OFF_MEM: begin
					rdat_r[DW-1:0] <= mem_r;
				end
				`RSSA_OFF_ACC: begin
					rdat_r[DW-1:0] <= acc_r;
				end
				`RSSA_OFF_IMM: begin
					rdat_r[DW-1:0] <= imm_r;
				end
				`RSSA_OFF_FLAGS: begin
					rdat_r[`RSSA_FL_SIGNED_RANGE:`RSSA_FL_C] <= flags_r;
				end
				`RSSA_OFF_STAT: begin
					rdat_r[`RSSA_ST_CYC_MSB:0] <= {cycles_r, skipped_r, !idle};
				end
				default: begin
					rdat_r <= 32'h0000_0000;
				end
			endcase
		end
	end

	// Previous-cycle copies, read only by the checks below.
	logic [DW-1:0] pm_r;
	logic [DW-1:0] pa_r;
	rssa_flags_t pf_r;
	always_ff @(posedge clk_i) begin
		pm_r <= mem_r;
		pa_r <= acc_r;
		pf_r <= flags_r;
	end

	// Checks share the block clock and reset.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Execute of a given operation.
	sequence run_s(rssa_op_t o);
		state_r == st_exec && op_r == o;
	endsequence
	// Dropped fetch: dummy cycle with skip shown, then idle.
	sequence dummy_s;
		state_r == st_dummy && skip_r ##1 state_r == st_idle;
	endsequence

	chk_rotl_cy_mem: assert property (run_s(op_rotate_left_through_cy) |=>
		mem_r == {pm_r[6:0], pf_r.c} && flags_r.c == pm_r[7] && flags_r.z == pf_r.z)
		else $error("rotate left through carry wrong");
	chk_rotl_cy_acc: assert property (run_s(op_rotate_left_through_cy_to_accum) |=>
		acc_r == {pm_r[6:0], pf_r.c} && mem_r == pm_r && flags_r.c == pm_r[7])
		else $error("rotate left to accumulator wrong");
	chk_rotr_mem_flags: assert property (run_s(op_rotate_right_plain) |=>
		mem_r == {pm_r[0], pm_r[7:1]} && flags_r == pf_r)
		else $error("plain rotate right wrong");
	chk_rotr_acc_only: assert property (run_s(op_rotate_right_to_accum) |=>
		acc_r == {pm_r[0], pm_r[7:1]} && $stable(mem_r) && $stable(flags_r))
		else $error("rotate right to accumulator wrong");
	chk_rotr_cy_mem: assert property (run_s(op_rotate_right_through_cy) |=>
		mem_r == {pf_r.c, pm_r[7:1]} && flags_r.c == pm_r[0] && flags_r.signed_range_flag == pf_r.signed_range_flag)
		else $error("rotate right through carry wrong");
	chk_rotr_cy_acc: assert property (run_s(op_rotate_right_through_cy_to_accum) |=>
		acc_r == {pf_r.c, pm_r[7:1]} && mem_r == pm_r && flags_r.c == pm_r[0])
		else $error("rotate right through carry to accumulator wrong");
	chk_borrow_acc_sum: assert property (run_s(op_minus_with_borrow) |=>
		{flags_r.c, acc_r} == {1'b0, pa_r} + {1'b0, ~pm_r} + {8'h00, pf_r.c} && flags_r.z == (acc_r == 8'h00))
		else $error("borrow subtract into accumulator wrong");
	chk_borrow_mem_sum: assert property (run_s(op_minus_with_borrow_to_mem) |=>
		{flags_r.c, mem_r} == {1'b0, pa_r} + {1'b0, ~pm_r} + {8'h00, pf_r.c} && acc_r == pa_r)
		else $error("borrow subtract into memory wrong");
	chk_dec_skip_time: assert property (run_s(op_decrement_skip_zero) ##0 mem_r == 8'h01 |=>
		mem_r == 8'h00 && flags_r == pf_r ##0 dummy_s)
		else $error("decrement skip timing wrong");
	chk_inc_noskip: assert property (run_s(op_increment_skip_zero) ##0 mem_r != 8'hFF |=>
		state_r == st_idle && !skip_r && cycles_r == 2'h1)
		else $error("increment without skip wrong");
	chk_set_byte: assert property (run_s(op_set_byte) |=>
		mem_r == 8'hFF && flags_r == pf_r)
		else $error("byte set wrong");
	chk_bit_skip: assert property (run_s(op_skip_bit_nonzero) |=>
		skip_r == pm_r[bit_r] && mem_r == pm_r && flags_r == pf_r)
		else $error("bit skip wrong");
	chk_swap_nibble: assert property (run_s(op_swap_nibbles) |=>
		mem_r == {pm_r[3:0], pm_r[7:4]} && flags_r == pf_r)
		else $error("nibble swap wrong");

endmodule

// [core/rssa_defs.svh]
// Register offsets, field positions, reset values and timing counts of the datapath block.
`ifndef RSSA_DEFS_SVH
`define RSSA_DEFS_SVH
`define RSSA_OFF_CTRL 8'h00
`define RSSA_OFF_MEM 8'h04
`define RSSA_OFF_ACC 8'h08
`define RSSA_OFF_IMM 8'h0C
`define RSSA_OFF_FLAGS 8'h10
`define RSSA_OFF_STAT 8'h14
`define RSSA_CTRL_OP_LSB 0
`define RSSA_CTRL_OP_MSB 4
`define RSSA_CTRL_BIT_LSB 5
`define RSSA_CTRL_BIT_MSB 7
`define RSSA_FL_C 0
`define RSSA_FL_HALF_CARRY 1
`define RSSA_FL_Z 2
`define RSSA_FL_SIGNED_RANGE 3
`define RSSA_ST_BUSY 0
`define RSSA_ST_SKIP 1
`define RSSA_ST_CYC_LSB 2
`define RSSA_ST_CYC_MSB 3
`define RSSA_RST_BYTE 8'h00
`define RSSA_RST_FLAGS 4'h0
`define RSSA_ALL_ONES 8'hFF
`define RSSA_CYC_RUN 2'h1
`define RSSA_CYC_SKIP 2'h2
`endif

// [core/rssa_pkg.sv]
// Types shared by the rotate, subtract and skip datapath block.
package rssa_pkg;
	// Status flags as one carrier, bit order matches the flag register.
	typedef struct packed {
		logic signed_range_flag;
		logic z;
		logic half_carry_flag;
		logic c;
	} rssa_flags_t;
	// Operation codes written into the control register.
	typedef enum logic [4:0] {
		op_rotate_left_through_cy = 5'h00,
		op_rotate_left_through_cy_to_accum = 5'h01,
		op_rotate_right_plain = 5'h02,
		op_rotate_right_to_accum = 5'h03,
		op_rotate_right_through_cy = 5'h04,
		op_rotate_right_through_cy_to_accum = 5'h05,
		op_minus_with_borrow = 5'h06,
		op_minus_with_borrow_to_mem = 5'h07,
		op_decrement_skip_zero = 5'h08,
		op_decrement_to_accum_skip_zero = 5'h09,
		op_increment_skip_zero = 5'h0A,
		op_increment_to_accum_skip_zero = 5'h0B,
		op_skip_bit_nonzero = 5'h0C,
		op_minus = 5'h0D,
		op_minus_to_mem = 5'h0E,
		op_minus_imm = 5'h0F,
		op_set_byte = 5'h10,
		op_set_bit = 5'h11,
		op_swap_nibbles = 5'h12
	} rssa_op_t;
	// One-hot execution states.
	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_exec = 3'b010,
		st_dummy = 3'b100
	} rssa_state_t;
endpackage

// [verification/rssa_tb.sv]
// Self-checking testbench for the rotate, subtract and skip datapath block.
`timescale 1ns/1ps
`include "rssa_defs.svh"

module tb
	import rssa_pkg::*;
;
	// Expected outcome of one operation.
	typedef struct packed {
		logic [7:0] m;
		logic [7:0] a;
		logic [3:0] f;
		logic sk;
	} rssa_exp_t;
	// Clock and reset.
	logic clk_i;
	logic rst_i;
	// Wishbone master signals driven by the bench.
	logic wb_cyc_i;
	logic wb_stb_i;
	logic wb_we_i;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic skip_o;
	rssa_flags_t flags_o;
	// Bookkeeping of comparisons and dummy cycles seen.
	int miscompares = 0;
	int checks = 0;
	int skip_cnt = 0;
	// Operand sets: carry in, borrow out, zero results and flag preservation.
	logic [7:0] vm [3] = '{8'h81, 8'h01, 8'hFF};
	logic [7:0] va [3] = '{8'h7F, 8'h00, 8'h10};
	logic [7:0] vx [3] = '{8'h80, 8'h01, 8'h0F};
	logic [3:0] vf [3] = '{4'h1, 4'h0, 4'hE};
	logic [2:0] vb [3] = '{3'h0, 3'h1, 3'h7};

	rssa_alu DUT (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.skip_o(skip_o),
		.flags_o(flags_o)
	);

	// Free-running 250 MHz clock.
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// Counts cycles in which the fetch path is told to discard.
	always @(posedge clk_i) begin
		if (skip_o === 1'b1) begin
			skip_cnt <= skip_cnt + 1;
		end
	end

	// Prints the verdict and ends the run.
	task automatic stop_test();
		if (miscompares == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// One comparison; a mismatch is reported at once.
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One classic single bus cycle, held until ack is sampled high.
	task automatic wb_cycle(input logic [7:0] adr, input logic we, input logic [3:0] sel,
		input logic [7:0] dat, output logic [31:0] rd);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= {24'h000000, dat};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			miscompares++;
			$display("unexpected ack timeout expected 1 seen %b", wb_ack_o);
			stop_test();
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		// The strobe stays low for one cycle between requests.
		@(posedge clk_i);
	endtask

	// Full-lane register write.
	task automatic wb_write(input logic [7:0] adr, input logic [7:0] dat);
		logic [31:0] rd;
		wb_cycle(adr, 1'b1, 4'hF, dat, rd);
	endtask

	// Register read compared with an expected word.
	task automatic wb_read(input string name, input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] rd;
		wb_cycle(adr, 1'b0, 4'hF, 8'h00, rd);
		chk(name, exp, rd);
	endtask

	// Reference behaviour of every operation code, flags packed as signed range, zero, half carry, carry.
	function automatic rssa_exp_t model(input logic [4:0] op, input logic [2:0] b, input logic [7:0] m,
		input logic [7:0] a, input logic [7:0] x, input logic [3:0] f);
		rssa_exp_t e;
		logic [7:0] d;
		logic cin;
		logic [8:0] s;
		logic [4:0] h;
		logic [3:0] sf;
		e = '{m: m, a: a, f: f, sk: 1'b0};
		d = (op == 5'h0F) ? ~x : ~m;
		cin = (op == 5'h06 || op == 5'h07) ? f[0] : 1'b1;
		s = {1'b0, a} + {1'b0, d} + {8'h00, cin};
		h = {1'b0, a[3:0]} + {1'b0, d[3:0]} + {4'h0, cin};
		sf = {(a[7] == d[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
		case (op)
			5'h00: begin
				e.m = {m[6:0], f[0]};
				e.f[0] = m[7];
			end
			5'h01: begin
				e.a = {m[6:0], f[0]};
				e.f[0] = m[7];
			end
			5'h02: e.m = {m[0], m[7:1]};
			5'h03: e.a = {m[0], m[7:1]};
			5'h04: begin
				e.m = {f[0], m[7:1]};
				e.f[0] = m[0];
			end
			5'h05: begin
				e.a = {f[0], m[7:1]};
				e.f[0] = m[0];
			end
			5'h06, 5'h0D, 5'h0F: begin
				e.a = s[7:0];
				e.f = sf;
			end
			5'h07, 5'h0E: begin
				e.m = s[7:0];
				e.f = sf;
			end
			5'h08: begin
				e.m = m - 8'h01;
				e.sk = (m == 8'h01);
			end
			5'h09: begin
				e.a = m - 8'h01;
				e.sk = (m == 8'h01);
			end
			5'h0A: begin
				e.m = m + 8'h01;
				e.sk = (m == 8'hFF);
			end
			5'h0B: begin
				e.a = m + 8'h01;
				e.sk = (m == 8'hFF);
			end
			5'h0C: e.sk = m[b];
			5'h10: e.m = `RSSA_ALL_ONES;
			5'h11: e.m = m | (8'h01 << b);
			5'h12: e.m = {m[3:0], m[7:4]};
			default: e.m = m;
		endcase
		return e;
	endfunction

	// Loads operands, starts one operation for each set and checks every result.
	task automatic run_op(input logic [4:0] op);
		rssa_exp_t e;
		int base;
		for (int i = 0; i < 3; i++) begin
			e = model(op, vb[i], vm[i], va[i], vx[i], vf[i]);
			wb_write(`RSSA_OFF_MEM, vm[i]);
			wb_write(`RSSA_OFF_ACC, va[i]);
			wb_write(`RSSA_OFF_IMM, vx[i]);
			wb_write(`RSSA_OFF_FLAGS, {4'h0, vf[i]});
			base = skip_cnt;
			wb_write(`RSSA_OFF_CTRL, {vb[i], op});
			wb_read("memory byte", `RSSA_OFF_MEM, {24'h000000, e.m});
			wb_read("accumulator", `RSSA_OFF_ACC, {24'h000000, e.a});
			wb_read("flags register", `RSSA_OFF_FLAGS, {28'h0000000, e.f});
			wb_read("status", `RSSA_OFF_STAT, {28'h0000000, e.sk ? `RSSA_CYC_SKIP : `RSSA_CYC_RUN, e.sk, 1'b0});
			chk("flags port", {28'h0000000, e.f}, {28'h0000000, flags_o});
			chk("dummy cycles", {31'h00000000, e.sk}, skip_cnt - base);
		end
	endtask

	// Main sequence.
	initial begin
		logic [31:0] rd;
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h00000000;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// Everything starts cleared.
		wb_read("reset memory", `RSSA_OFF_MEM, 32'h00000000);
		wb_read("reset accumulator", `RSSA_OFF_ACC, 32'h00000000);
		wb_read("reset flags", `RSSA_OFF_FLAGS, 32'h00000000);
		chk("reset skip", 32'h00000000, {31'h00000000, skip_o});
		// Unmapped and lane-disabled writes leave the operands alone.
		wb_write(`RSSA_OFF_MEM, 8'h5A);
		wb_write(8'h18, 8'hA5);
		wb_cycle(`RSSA_OFF_MEM, 1'b1, 4'hE, 8'h3C, rd);
		wb_read("unmapped read", 8'h18, 32'h00000000);
		wb_read("guarded memory", `RSSA_OFF_MEM, 32'h0000005A);
		// Every operation code, each with three operand sets.
		run_op(5'h00);
		run_op(5'h01);
		run_op(5'h02);
		run_op(5'h03);
		run_op(5'h04);
		run_op(5'h05);
		run_op(5'h06);
		run_op(5'h07);
		run_op(5'h08);
		run_op(5'h09);
		run_op(5'h0A);
		run_op(5'h0B);
		run_op(5'h0C);
		run_op(5'h0D);
		run_op(5'h0E);
		run_op(5'h0F);
		run_op(5'h10);
		run_op(5'h11);
		run_op(5'h12);
		// An unused code must change nothing.
		run_op(5'h13);
		stop_test();
	end
endmodule
